// ==== design/icc_map.svh ====
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ICC_CTRL_OFFSET   12'h000
`define ICC_FIFO_OFFSET   12'h004

// ----------------------------------------------------------------
// Control word fields and reset
// ----------------------------------------------------------------
`define ICC_CTRL_RESET    16'h0000
`define ICC_SIDL_BIT      13
`define ICC_TSEL_BIT      7
`define ICC_IPER_HI       6
`define ICC_IPER_LO       5
`define ICC_OVF_BIT       4
`define ICC_BNE_BIT       3
`define ICC_MODE_HI       2
`define ICC_MODE_LO       0

// ----------------------------------------------------------------
// Edge prescaler terminal counts
// ----------------------------------------------------------------
`define ICC_PRE4_LAST     4'h3
`define ICC_PRE16_LAST    4'hf

`endif

// ==== design/icc_pkg.sv ====
package icc_pkg;

    typedef enum logic [2:0] {
        icc_mode_off    = 3'h0,
        icc_mode_both   = 3'h1,
        icc_mode_fall   = 3'h2,
        icc_mode_rise   = 3'h3,
        icc_mode_rise4  = 3'h4,
        icc_mode_rise16 = 3'h5,
        icc_mode_unused = 3'h6,
        icc_mode_wake   = 3'h7
    } icc_mode_e;

    typedef struct packed {
        logic       stop_in_idle;
        logic       timer_select;
        logic [1:0] captures_per_interrupt;
        icc_mode_e  capture_mode;
    } icc_ctrl_s;

endpackage : icc_pkg

// ==== design/icc_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module icc_pin_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } icc_sync_s;

    icc_sync_s s;
    icc_sync_s next_s;

    // A change is taken only once the second and third stage agree
    always_comb begin
        next_s      = s;
        next_s.s1   = pin;
        next_s.s2   = s.s1;
        next_s.s3   = s.s2;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (s.s2 == s.s3 && s.s3 != s.level) begin
            next_s.level = s.s3;
            next_s.rise  = s.s3;
            next_s.fall  = ~s.s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise = s.rise;
    assign fall = s.fall;

endmodule : icc_pin_sync

`default_nettype wire

// ==== design/icc_skid2.sv ====
`timescale 1ns/1ps
`default_nettype none

module icc_skid2 #(
    parameter int WIDTH = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wr;
        logic                  rd;
        logic [1:0]            count;
    } icc_skid_s;

    icc_skid_s s;
    icc_skid_s next_s;
    logic      push;
    logic      pop;

    always_comb begin
        next_s = s;
        push   = in_valid && (s.count != 2'h2);
        pop    = out_ready && (s.count != 2'h0);
        if (push) begin
            next_s.mem[s.wr] = in_data;
            next_s.wr        = ~s.wr;
        end
        if (pop) begin
            next_s.rd = ~s.rd;
        end
        next_s.count = s.count + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            next_s.wr    = 1'b0;
            next_s.rd    = 1'b0;
            next_s.count = 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready  = (s.count != 2'h2);
    assign out_valid = (s.count != 2'h0);
    assign out_data  = s.mem[s.rd];

endmodule : icc_skid2

`default_nettype wire

// ==== design/icc_input_capture_channel.sv ====
// Behaviour
// - Stop-in-idle set halts channel during Idle, except the mode 111 wake interrupt
// - Timer select 1 picks timer two, else three
// - Interrupt every 1, 2, 3 or 4 captures
// - Overflow flag read-only, hardware cleared, resets 0
// - Not-empty bit shows unread captured words
// - Mode 111 is rising-edge wake interrupt only
// - Mode 110 behaves as disabled
// - Mode 101 captures every 16th rising edge
// - Mode 100 captures every 4th rising edge
// - Mode 011 captures every rising edge
// - Mode 010 captures every falling edge
// - Mode 001 both edges, interrupt every capture
// - Mode 000 switches the channel off
// - Unimplemented bits read zero, all reset 0
// - Capture stores the 16-bit timer count
// - Four-word FIFO, read oldest first
// - Pin event can wake from Sleep or Idle
`timescale 1ns/1ps
`default_nettype none
`include "icc_map.svh"

module icc_input_capture_channel #(
    parameter int WIDTH  = 16,
    parameter int DEPTH  = 4,
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              capture_input_pin,
    input  wire logic [WIDTH-1:0]  timer_two_count,
    input  wire logic [WIDTH-1:0]  timer_three_count,
    input  wire logic              cpu_idle,
    input  wire logic              cpu_sleep,
    output logic                   capture_irq,
    output logic                   wake_request
);

    localparam int PTR_W  = $clog2(DEPTH);
    localparam int FILL_W = PTR_W + 1;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        icc_pkg::icc_ctrl_s              ctrl;
        logic                            overflow_flag;
        logic [3:0]                      prescale;
        logic [1:0]                      irq_count;
        logic [DEPTH-1:0][WIDTH-1:0]     fifo_mem;
        logic [PTR_W-1:0]                wr_ptr;
        logic [PTR_W-1:0]                rd_ptr;
        logic [FILL_W-1:0]               fill;
        logic [31:0]                     prdata;
        logic                            pready;
        logic                            pslverr;
        logic                            capture_irq;
        logic                            wake_request;
    } icc_state_s;

    icc_state_s s;
    icc_state_s next_s;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] ctrl_word(
        input icc_pkg::icc_ctrl_s c,
        input logic               ovf,
        input logic               bne
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`ICC_SIDL_BIT]                 = c.stop_in_idle;
        w[`ICC_TSEL_BIT]                 = c.timer_select;
        w[`ICC_IPER_HI:`ICC_IPER_LO]     = c.captures_per_interrupt;
        w[`ICC_OVF_BIT]                  = ovf;
        w[`ICC_BNE_BIT]                  = bne;
        w[`ICC_MODE_HI:`ICC_MODE_LO]     = c.capture_mode;
        return w;
    endfunction : ctrl_word

    function automatic logic [3:0] prescale_last(
        input icc_pkg::icc_mode_e m
    );
        return (m == icc_pkg::icc_mode_rise16) ? `ICC_PRE16_LAST
                                               : `ICC_PRE4_LAST;
    endfunction : prescale_last

    // ----------------------------------------------------------------
    // Pin synchroniser and capture buffer
    // ----------------------------------------------------------------
    logic             pin_rise;
    logic             pin_fall;
    logic             skid_in_valid;
    logic             skid_in_ready;
    logic [WIDTH-1:0] skid_in_data;
    logic             skid_out_valid;
    logic [WIDTH-1:0] skid_out_data;
    logic             chan_off;
    logic             fifo_full;

    icc_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (capture_input_pin),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // Words wait here one cycle while the FIFO write settles; a stall
    // from a full FIFO is seen below and turned into an overflow
    icc_skid2 #(
        .WIDTH (WIDTH)
    ) u_skid (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (chan_off),
        .in_valid  (skid_in_valid),
        .in_ready  (skid_in_ready),
        .in_data   (skid_in_data),
        .out_valid (skid_out_valid),
        .out_ready (!fifo_full),
        .out_data  (skid_out_data)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    icc_pkg::icc_mode_e mode;
    logic               halted;
    logic               capturing;
    logic               edge_hit;
    logic               capture_ev;
    logic               accept;
    logic               push;
    logic               pop;
    logic               access;
    logic               hit_ctrl;
    logic               hit_fifo;

    always_comb begin
        next_s              = s;
        next_s.capture_irq  = 1'b0;
        next_s.wake_request = 1'b0;
        mode      = s.ctrl.capture_mode;
        chan_off  = (mode == icc_pkg::icc_mode_off)
                 || (mode == icc_pkg::icc_mode_unused);
        halted    = s.ctrl.stop_in_idle && cpu_idle;
        // Sleep stops the timers, so only the wake mode acts there
        capturing = !chan_off && (mode != icc_pkg::icc_mode_wake)
                 && !halted && !cpu_sleep;
        fifo_full = (s.fill == FILL_W'(DEPTH));
        access    = psel && penable;
        hit_ctrl  = 1'b0;
        hit_fifo  = 1'b0;
        if (paddr == `ICC_CTRL_OFFSET) begin
            hit_ctrl = 1'b1;
        end else if (paddr == `ICC_FIFO_OFFSET) begin
            hit_fifo = 1'b1;
        end

        edge_hit = 1'b0;
        case (mode)
            icc_pkg::icc_mode_both:   edge_hit = pin_rise || pin_fall;
            icc_pkg::icc_mode_fall:   edge_hit = pin_fall;
            icc_pkg::icc_mode_rise:   edge_hit = pin_rise;
            icc_pkg::icc_mode_rise4,
            icc_pkg::icc_mode_rise16: begin
                edge_hit = pin_rise
                        && (s.prescale == prescale_last(mode));
            end
            default:                  edge_hit = 1'b0;
        endcase
        capture_ev = capturing && edge_hit;

        if (capturing && pin_rise
                && (mode == icc_pkg::icc_mode_rise4
                 || mode == icc_pkg::icc_mode_rise16)) begin
            if (s.prescale == prescale_last(mode)) begin
                next_s.prescale = 4'h0;
            end else begin
                next_s.prescale = s.prescale + 4'h1;
            end
        end

        // Value sampled in the event cycle
        skid_in_data  = s.ctrl.timer_select ? timer_two_count
                                            : timer_three_count;
        accept        = !fifo_full && skid_in_ready;
        skid_in_valid = capture_ev && accept;
        if (capture_ev && !accept) begin
            next_s.overflow_flag = 1'b1;
        end

        if (capture_ev) begin
            if (mode == icc_pkg::icc_mode_both
                    || s.irq_count == s.ctrl.captures_per_interrupt) begin
                next_s.capture_irq = 1'b1;
                next_s.irq_count   = 2'h0;
            end else begin
                next_s.irq_count = s.irq_count + 2'h1;
            end
        end

        if (mode == icc_pkg::icc_mode_wake
                && (cpu_sleep || cpu_idle) && pin_rise) begin
            next_s.capture_irq  = 1'b1;
            next_s.wake_request = 1'b1;
        end

        push = skid_out_valid && !fifo_full;
        if (push) begin
            next_s.fifo_mem[s.wr_ptr] = skid_out_data;
            next_s.wr_ptr             = s.wr_ptr + PTR_W'(1);
        end

        // APB: setup, one wait cycle, then completion with pready
        pop = 1'b0;
        if (access && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = 1'b0;
            next_s.prdata  = 32'h0000_0000;
            if (hit_ctrl) begin
                next_s.prdata = ctrl_word(s.ctrl, s.overflow_flag,
                                          s.fill != '0);
            end else if (hit_fifo) begin
                next_s.prdata = 32'(s.fifo_mem[s.rd_ptr]);
            end else begin
                next_s.pslverr = 1'b1;
            end
        end else if (access && s.pready) begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
            if (pwrite && hit_ctrl) begin
                // Status bits are not writable
                next_s.ctrl.stop_in_idle = pwdata[`ICC_SIDL_BIT];
                next_s.ctrl.timer_select = pwdata[`ICC_TSEL_BIT];
                next_s.ctrl.captures_per_interrupt =
                    pwdata[`ICC_IPER_HI:`ICC_IPER_LO];
                next_s.ctrl.capture_mode = icc_pkg::icc_mode_e'(
                    pwdata[`ICC_MODE_HI:`ICC_MODE_LO]);
            end else if (!pwrite && hit_fifo && s.fill != '0) begin
                pop = 1'b1;
            end
        end else begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
        end
        if (pop) begin
            next_s.rd_ptr = s.rd_ptr + PTR_W'(1);
        end
        next_s.fill = s.fill + FILL_W'(push) - FILL_W'(pop);

        // Disabled channel restarts clean
        if (chan_off) begin
            next_s.prescale      = 4'h0;
            next_s.irq_count     = 2'h0;
            next_s.wr_ptr        = '0;
            next_s.rd_ptr        = '0;
            next_s.fill          = '0;
            next_s.overflow_flag = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata       = s.prdata;
    assign pready       = s.pready;
    assign pslverr      = s.pslverr;
    assign capture_irq  = s.capture_irq;
    assign wake_request = s.wake_request;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ctrl_read_setup;
        psel && !penable && !pwrite && paddr == `ICC_CTRL_OFFSET;
    endsequence

    sequence ctrl_read_done;
        (psel && penable && !pready) ##1 pready;
    endsequence

    a_idle_halt: assert property (
        (s.ctrl.stop_in_idle && cpu_idle) |-> !skid_in_valid)
        else $error("capture taken while halted in idle");
    a_timer_pick: assert property (
        skid_in_valid |-> skid_in_data == (s.ctrl.timer_select
            ? timer_two_count : timer_three_count))
        else $error("wrong timer captured");
    a_irq_rate: assert property (
        (capture_ev && mode != icc_pkg::icc_mode_both
            && s.irq_count != s.ctrl.captures_per_interrupt)
        |=> !capture_irq && s.irq_count == $past(s.irq_count) + 2'h1)
        else $error("interrupt raised too early");
    a_ovf_set: assert property (
        (capture_ev && fifo_full) |=> s.overflow_flag)
        else $error("overflow not flagged");
    a_ovf_hold: assert property (
        (s.overflow_flag && !chan_off) |=> s.overflow_flag)
        else $error("overflow cleared while enabled");
    a_bne_read: assert property (
        ctrl_read_setup ##0 (s.fill != '0) ##1 (s.fill != '0)
        ##1 pready |-> prdata[`ICC_BNE_BIT])
        else $error("not-empty bit wrong");
    a_reserved_zero: assert property (
        ctrl_read_setup ##1 ctrl_read_done
        |-> prdata[15:14] == 2'h0 && prdata[12:8] == 5'h00)
        else $error("unimplemented bits not zero");
    a_wake_pin: assert property (
        (mode == icc_pkg::icc_mode_wake && (cpu_sleep || cpu_idle)
            && pin_rise) |=> capture_irq && wake_request)
        else $error("wake interrupt missing");
    a_wake_quiet: assert property (
        (mode == icc_pkg::icc_mode_wake) |-> !skid_in_valid)
        else $error("capture in wake-only mode");
    a_off_clear: assert property (
        chan_off |=> s.fill == '0 && !s.overflow_flag
            && s.prescale == 4'h0)
        else $error("disabled channel not cleared");
    a_div_sixteen: assert property (
        (capture_ev && mode == icc_pkg::icc_mode_rise16)
        |-> s.prescale == 4'hf && pin_rise)
        else $error("16th edge capture misplaced");
    a_div_four: assert property (
        (capture_ev && mode == icc_pkg::icc_mode_rise4)
        |-> s.prescale == 4'h3 && pin_rise)
        else $error("4th edge capture misplaced");
    a_edge_rise: assert property (
        (capturing && mode == icc_pkg::icc_mode_rise && pin_rise
            && !fifo_full) |=> s.irq_count != $past(s.irq_count)
            || capture_irq)
        else $error("rising edge not captured");
    a_edge_fall: assert property (
        (mode == icc_pkg::icc_mode_fall && capture_ev) |-> pin_fall)
        else $error("falling mode took other edge");
    a_edge_both: assert property (
        (mode == icc_pkg::icc_mode_both && capture_ev) |=> capture_irq)
        else $error("both-edge capture without interrupt");

endmodule : icc_input_capture_channel

`default_nettype wire

// ==== tb/icc_pin_drv.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Far side: one high pulse on the capture pin per request
// ----------------------------------------------------------------
module icc_pin_drv (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic go,
    output logic      pin,
    output logic      busy
);
    logic [4:0] cnt;

    // The high level is held eight cycles and the low level ten after it, so the pin filter sees each settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 5'h00;
            pin <= 1'b0;
        end else if (go && cnt == 5'h00) begin
            cnt <= 5'h14;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
            if (cnt == 5'h12) pin <= 1'b1;
            if (cnt == 5'h0a) pin <= 1'b0;
        end
    end

    assign busy = (cnt != 5'h00);
endmodule : icc_pin_drv
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] t2, t3;
    logic        idle, sleep, irq, wake, pin, go, busy, err;
    int          num_errors, n_tests, irqs, wakes, i0, w0;

    icc_input_capture_channel icc_input_capture_channel_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_input_pin(pin),
        .timer_two_count(t2), .timer_three_count(t3), .cpu_idle(idle),
        .cpu_sleep(sleep), .capture_irq(irq), .wake_request(wake));
    icc_pin_drv icc_pin_drv_i (
        .pclk(pclk), .presetn(presetn), .go(go), .pin(pin), .busy(busy));

    // ----------------------------------------------------------------
    // Clock, event counters, watchdog
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (irq === 1'b1) irqs++;
        if (wake === 1'b1) wakes++;
    end
    initial begin
        #1_000_000;
        num_errors++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Bus and pin helpers
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [31:0] d); apb(1'b1, 12'h000, d);
    endtask : wr
    task automatic rdc(); apb(1'b0, 12'h000, 32'h0000_0000); endtask : rdc
    // Timer values stay put across the whole pulse, so latency is moot
    task automatic pulse(input logic [15:0] v2, input logic [15:0] v3);
        t2 <= v2; t3 <= v3; go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        do begin @(posedge pclk); end while (busy === 1'b1);
        repeat (8) @(posedge pclk);
    endtask : pulse
    task automatic pop(input logic [15:0] e);
        rdc(); `CHK(rd[3], 1'b1)
        apb(1'b0, 12'h004, 32'h0000_0000); `CHK(rd, {16'h0000, e})
    endtask : pop

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_regs();
        rdc(); `CHK(rd, 32'h0000_0000)
        apb(1'b0, 12'h008, 32'h0000_0000); `CHK(err, 1'b1)
        wr(32'h0000_FFFF); rdc(); `CHK(rd, 32'h0000_20E7)
        wr(32'h0000_0000);
    endtask : s_regs
    task automatic s_fifo();
        wr(32'h0000_0083); i0 = irqs;
        for (int i = 0; i < 5; i++) pulse(16'h2000 + 16'(i), 16'h3FFF);
        rdc(); `CHK(rd[4:3], 2'b11)
        `CHK(irqs - i0, 5)
        for (int i = 0; i < 4; i++) pop(16'h2000 + 16'(i));
        rdc(); `CHK(rd[4:3], 2'b10)
        wr(32'h0000_0000); rdc(); `CHK(rd, 32'h0000_0000)
        wr(32'h0000_0002); pulse(16'h1111, 16'h3A5C);
        pop(16'h3A5C);
        wr(32'h0000_0000);
    endtask : s_fifo
    task automatic s_pre();
        for (int m = 4; m < 6; m++) begin
            wr(32'(m));
            for (int i = 0; i < (m == 4 ? 3 : 15); i++) pulse(16'h0, 16'h4444);
            rdc(); `CHK(rd[3], 1'b0)
            pulse(16'h0, 16'h5A5A); pop(16'h5A5A);
            wr(32'h0000_0000);
        end
    endtask : s_pre
    task automatic s_ici();
        for (int c = 0; c < 4; c++) begin
            wr(32'h0000_0003 | 32'(c << 5)); i0 = irqs;
            for (int i = 0; i < 4; i++) pulse(16'h0, 16'h0);
            `CHK(irqs - i0, 4 / (c + 1))
            wr(32'h0000_0000);
        end
        wr(32'h0000_0061); i0 = irqs; pulse(16'h0, 16'h0);
        `CHK(irqs - i0, 2)
        wr(32'h0000_0000);
    endtask : s_ici
    task automatic s_off_idle();
        for (int m = 0; m < 7; m += 6) begin
            wr(32'(m)); i0 = irqs; pulse(16'h0, 16'h0); rdc();
            `CHK(rd[3], 1'b0)
            `CHK(irqs - i0, 0)
        end
        idle <= 1'b1;
        wr(32'h0000_2003); pulse(16'h0, 16'h0); rdc();
        `CHK(rd[3], 1'b0)
        wr(32'h0000_0003); pulse(16'h0, 16'h0); rdc();
        `CHK(rd[3], 1'b1)
        idle <= 1'b0;
        wr(32'h0000_0000);
    endtask : s_off_idle
    task automatic s_wake();
        wr(32'h0000_0007); w0 = wakes; i0 = irqs; pulse(16'h0, 16'h0);
        `CHK(wakes - w0, 0)
        sleep <= 1'b1; pulse(16'h0, 16'h0);
        `CHK(wakes - w0, 1)
        `CHK(irqs - i0, 1)
        rdc(); `CHK(rd[3], 1'b0)
        sleep <= 1'b0;
        wr(32'h0000_0000);
    endtask : s_wake

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; t2 = 16'h0000;
        t3 = 16'h0000; idle = 1'b0; sleep = 1'b0; go = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_fifo();
        s_pre();
        s_ici();
        s_off_idle();
        s_wake();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
